// file: rtl/sfc_frame.sv
`timescale 1ns/100ps
// What this block does
// - all fields shift most significant bit first from first rising clock after select low
// - each input bit is taken on a rising serial clock edge
// - frames open with one opcode byte, then address, data, both or nothing
// - status reads and release-with-id stream output while the clock runs
// - host may end any read after any bit; block returns to deselected
// - write-type frames count clocks; select rising off a byte boundary discards them
// - page program cut mid-byte does nothing and leaves write enable latch set
// - erase or program aimed at a protected region is ignored
// - write enable, write disable, deep power-down are checked on byte boundary
// - sector and block erases take three address bytes and are checked
// - page program, chip erase and status write need select rise on a boundary
// - read outputs right after address; fast read adds one dummy byte
// - dual output read takes address and dummy, then streams on two lines
// - quad output read takes address and dummy, then streams on four lines
// - octal word read takes address and mode, then data without dummy
// - opcode 50h enables one volatile status register write
// - modifying commands need the write enable latch set first; status write also accepts the 50h enable
module sfc_frame
  import sfc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_out,
  input  wire logic [7:0]  rd_data_in,
  input  wire logic        prot_hit_in,
  output logic             cmd_valid_out,
  output sfc_cmd_t         cmd_out,
  output logic             wr_byte_valid_out,
  output logic      [7:0]  wr_byte_out,
  output logic             rd_req_out,
  output logic             write_enable_latch_out,
  output logic             vsr_wen_out,
  output logic             deep_pd_out
);

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_OP    = 6'b000010,
    ST_ADDR  = 6'b000100,
    ST_DUMMY = 6'b001000,
    ST_DATA  = 6'b010000,
    ST_IGN   = 6'b100000
  } sfc_state_t;

  // opcode table, used for both the live shift and the stored opcode
  function automatic sfc_dec_t decode(input logic [7:0] op);
    sfc_dec_t d;
    d = '0;
    d.in_w = SFC_W1;
    d.out_w = SFC_W1;
    d.known = 1'b1;
    unique case (op)
      OP_WRITE_ENABLE_CMD, OP_WRDIS, OP_DPD, OP_CE1, OP_CE2: d.wr_type = 1'b1;
      OP_WRSR: d.wr_type = 1'b1;
      OP_VSR_EN: d.known = 1'b1;
      OP_SE, OP_BE32, OP_BE64: begin
        d.wr_type = 1'b1;
        d.has_addr = 1'b1;
      end
      OP_PP: begin
        d.wr_type = 1'b1;
        d.has_addr = 1'b1;
      end
      OP_RDSR1, OP_RDSR2, OP_RDP: d.rd_type = 1'b1;
      OP_READ: begin
        d.rd_type = 1'b1;
        d.has_addr = 1'b1;
      end
      OP_FREAD: begin
        d.rd_type = 1'b1;
        d.has_addr = 1'b1;
        d.dummy = 2'h1;
      end
      OP_DREAD: begin
        d.rd_type = 1'b1;
        d.has_addr = 1'b1;
        d.dummy = 2'h1;
        d.out_w = SFC_W2;
      end
      OP_QREAD: begin
        d.rd_type = 1'b1;
        d.has_addr = 1'b1;
        d.dummy = 2'h1;
        d.out_w = SFC_W4;
      end
      OP_OCTW: begin
        d.rd_type = 1'b1;
        d.has_addr = 1'b1;
        d.has_mode = 1'b1;
        d.in_w = SFC_W4;
        d.out_w = SFC_W4;
      end
      OP_QIO: begin
        d.rd_type = 1'b1;
        d.has_addr = 1'b1;
        d.has_mode = 1'b1;
        d.dummy = 2'h2;
        d.in_w = SFC_W4;
        d.out_w = SFC_W4;
      end
      OP_DIO: begin
        d.rd_type = 1'b1;
        d.has_addr = 1'b1;
        d.has_mode = 1'b1;
        d.in_w = SFC_W2;
        d.out_w = SFC_W2;
      end
      default: d.known = 1'b0;
    endcase
    return d;
  endfunction

  // bits carried per clock for a width code
  function automatic logic [3:0] lanes(input sfc_width_t w);
    unique case (w)
      SFC_W1: return 4'h1;
      SFC_W2: return 4'h2;
      SFC_W4: return 4'h4;
      default: return 4'h1;
    endcase
  endfunction

  logic             rst_s1_r, rst_n_r;
  logic [2:0]       cs_sync_r, clk_sync_r;
  logic [3:0]       io_s1_r, io_s2_r;
  sfc_state_t       state_r;
  logic [7:0]       op_r;
  logic [31:0]      sh_r;        // address plus mode shifter
  logic [5:0]       need_r;      // bits left in current phase
  logic [BIT_CNT_W-1:0] clk_cnt_r;
  logic [7:0]       out_sh_r;
  logic [3:0]       out_left_r;
  logic [7:0]       in_byte_r;
  logic [2:0]       in_bits_r;
  logic             write_enable_latch_r, vsr_r, dpd_r;
  sfc_dec_t         dec;
  logic             rise, fall, cs_low, cs_rise, cs_fall;
  logic [3:0]       ln;

  // reset release through two flops
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // pin synchronisers; stage 0 feeds only stage 1, stages 1 and 2 give edges
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cs_sync_r <= 3'h7;
      clk_sync_r <= 3'h0;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], cs_n_in};
      clk_sync_r <= {clk_sync_r[1:0], sclk_in};
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  assign cs_low  = !cs_sync_r[1];
  assign cs_fall = cs_sync_r[2] && !cs_sync_r[1];
  assign cs_rise = !cs_sync_r[2] && cs_sync_r[1];
  assign rise    = cs_low && !clk_sync_r[2] && clk_sync_r[1];
  assign fall    = cs_low && clk_sync_r[2] && !clk_sync_r[1];
  assign dec     = decode(op_r);
  assign ln      = (state_r == ST_DATA) ? 4'h1 : lanes(dec.in_w);

  // frame sequencer; the host raising select ends any phase at once
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      op_r <= 8'h00;
      sh_r <= 32'h0;
      need_r <= 6'h0;
    end else if (!cs_low) begin
      state_r <= ST_IDLE;
    end else if (cs_fall || state_r == ST_IDLE) begin
      state_r <= ST_OP;
      need_r <= 6'd8;
    end else if (rise) begin
      unique case (state_r)
        ST_OP: begin
          op_r <= {op_r[6:0], io_s2_r[0]};
          if (need_r == 6'd1) begin
            if (dpd_r && {op_r[6:0], io_s2_r[0]} != OP_RDP) state_r <= ST_IGN;
            else if (!decode({op_r[6:0], io_s2_r[0]}).known) state_r <= ST_IGN;
            else if (decode({op_r[6:0], io_s2_r[0]}).has_addr) begin
              state_r <= ST_ADDR;
              need_r <= decode({op_r[6:0], io_s2_r[0]}).has_mode ? 6'd32 : 6'd24;
            end else state_r <= ST_DATA;
          end else need_r <= need_r - 6'd1;
        end
        ST_ADDR: begin
          // lanes shift msb first, high lane carrying the higher bit
          unique case (dec.in_w)
            SFC_W4: sh_r <= {sh_r[27:0], io_s2_r};
            SFC_W2: sh_r <= {sh_r[29:0], io_s2_r[1:0]};
            default: sh_r <= {sh_r[30:0], io_s2_r[0]};
          endcase
          if (need_r <= {2'b00, ln}) begin
            state_r <= (dec.dummy != 2'h0) ? ST_DUMMY : ST_DATA;
            need_r <= {dec.dummy, 3'b000} - 6'd1;
          end else need_r <= need_r - {2'b00, ln};
        end
        ST_DUMMY: begin
          if (need_r == 6'h0) state_r <= ST_DATA;
          else need_r <= need_r - 6'd1;
        end
        ST_DATA, ST_IGN: state_r <= state_r;
        default: state_r <= ST_IGN;
      endcase
    end
  end

  // clocks since select fell; wide enough for long program frames
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) clk_cnt_r <= '0;
    else if (cs_fall) clk_cnt_r <= '0;
    else if (rise) clk_cnt_r <= clk_cnt_r + 1'b1;
  end

  // latch and mode state; executes only on a clean byte-boundary end
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      write_enable_latch_r <= 1'b0;
      vsr_r <= 1'b0;
      dpd_r <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_out <= '0;
    end else begin
      cmd_valid_out <= 1'b0;
      if (cs_rise && state_r != ST_IGN && state_r != ST_OP && clk_cnt_r[2:0] == 3'h0) begin
        unique case (op_r)
          OP_WRITE_ENABLE_CMD: write_enable_latch_r <= 1'b1;
          OP_WRDIS: begin
            write_enable_latch_r <= 1'b0;
            vsr_r <= 1'b0;
          end
          OP_VSR_EN: vsr_r <= 1'b1;
          OP_DPD: dpd_r <= 1'b1;
          OP_RDP: dpd_r <= 1'b0;
          OP_WRSR: if ((write_enable_latch_r || vsr_r) && clk_cnt_r >= 16'h10) begin
            cmd_valid_out <= 1'b1;
            cmd_out <= '{opcode: op_r, addr: 24'h0, mode: 8'h00};
            write_enable_latch_r <= 1'b0;
            vsr_r <= 1'b0;
          end
          OP_PP, OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2:
            if (write_enable_latch_r && !prot_hit_in && state_r != ST_ADDR) begin
              cmd_valid_out <= 1'b1;
              cmd_out <= '{opcode: op_r, addr: sh_r[23:0], mode: 8'h00};
              write_enable_latch_r <= 1'b0;
            end
          default: write_enable_latch_r <= write_enable_latch_r;
        endcase
      end else if (state_r == ST_DATA && dec.rd_type && rise) begin
        cmd_out <= '{opcode: op_r, addr: dec.has_mode ? sh_r[31:8] : sh_r[23:0],
                     mode: dec.has_mode ? sh_r[7:0] : 8'h00};
      end
    end
  end

  // program data bytes collected msb first for the back end
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      in_byte_r <= 8'h00;
      in_bits_r <= 3'h0;
      wr_byte_valid_out <= 1'b0;
      wr_byte_out <= 8'h00;
    end else begin
      wr_byte_valid_out <= 1'b0;
      if (state_r != ST_DATA) in_bits_r <= 3'h0;
      else if (rise && op_r == OP_PP || rise && op_r == OP_WRSR) begin
        in_byte_r <= {in_byte_r[6:0], io_s2_r[0]};
        in_bits_r <= in_bits_r + 3'h1;
        if (in_bits_r == 3'h7) begin
          wr_byte_valid_out <= 1'b1;
          wr_byte_out <= {in_byte_r[6:0], io_s2_r[0]};
        end
      end
    end
  end

  // output shifter; changes on falling edge so host samples on rising
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_sh_r <= 8'h00;
      out_left_r <= 4'h0;
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
      rd_req_out <= 1'b0;
    end else begin
      rd_req_out <= 1'b0;
      if (!cs_low || state_r != ST_DATA || !dec.rd_type) begin
        out_left_r <= 4'h0;
        io_oe_out <= 4'h0;
      end else if (fall) begin
        if (out_left_r == 4'h0) begin // repeats while clocked
          out_sh_r <= rd_data_in;
          out_left_r <= 4'd8 - lanes(dec.out_w);
          rd_req_out <= 1'b1;
          unique case (dec.out_w)
            SFC_W4: io_out <= rd_data_in[7:4];
            SFC_W2: io_out <= {2'b00, rd_data_in[7:6]};
            default: io_out <= {2'b00, rd_data_in[7], 1'b0};
          endcase
          unique case (dec.out_w)
            SFC_W4: io_oe_out <= 4'hf;
            SFC_W2: io_oe_out <= 4'h3;
            default: io_oe_out <= 4'h2;
          endcase
        end else begin
          out_left_r <= out_left_r - lanes(dec.out_w);
          unique case (dec.out_w)
            SFC_W4: io_out <= out_sh_r[3:0];
            SFC_W2: io_out <= {2'b00, out_sh_r[3'(out_left_r - 4'h1) -: 2]};
            default: io_out <= {2'b00, out_sh_r[3'(out_left_r - 4'h1)], 1'b0};
          endcase
        end
      end
    end
  end

  assign write_enable_latch_out = write_enable_latch_r;
  assign vsr_wen_out = vsr_r;
  assign deep_pd_out = dpd_r;

endmodule

// file: rtl/sfc_pkg.sv
package sfc_pkg;

  // opcode codes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRDIS   = 8'h04;
  localparam logic [7:0] OP_VSR_EN  = 8'h50;
  localparam logic [7:0] OP_RDSR1   = 8'h05;
  localparam logic [7:0] OP_RDSR2   = 8'h35;
  localparam logic [7:0] OP_WRSR    = 8'h01;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_FREAD   = 8'h0b;
  localparam logic [7:0] OP_DREAD   = 8'h3b;
  localparam logic [7:0] OP_QREAD   = 8'h6b;
  localparam logic [7:0] OP_OCTW    = 8'he3;
  localparam logic [7:0] OP_DIO     = 8'hbb;
  localparam logic [7:0] OP_QIO     = 8'heb;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_SE      = 8'h20;
  localparam logic [7:0] OP_BE32    = 8'h52;
  localparam logic [7:0] OP_BE64    = 8'hd8;
  localparam logic [7:0] OP_CE1     = 8'hc7;
  localparam logic [7:0] OP_CE2     = 8'h60;
  localparam logic [7:0] OP_DPD     = 8'hb9;
  localparam logic [7:0] OP_RDP     = 8'hab;

  // address length in bytes, clock counter width in bits
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam int         BIT_CNT_W  = 16;

  // bus widths mode for address phase and data output
  typedef enum logic [1:0] {
    SFC_W1 = 2'h0,
    SFC_W2 = 2'h1,
    SFC_W4 = 2'h2
  } sfc_width_t;

  // decoded opcode properties
  typedef struct packed {
    logic       known;
    logic       wr_type;    // subject to byte-boundary check
    logic       rd_type;    // has a data-out phase
    logic       has_addr;
    logic       has_mode;
    logic [1:0] dummy;      // dummy bytes after address or mode
    sfc_width_t in_w;       // width of address and mode phase
    sfc_width_t out_w;      // width of data-out phase
  } sfc_dec_t;

  // command handed to the array and register back end
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  mode;
  } sfc_cmd_t;

endpackage

// file: testbench/sfc_frame_assertions.sv
`timescale 1ns/100ps
// pin-level watch on the frame decoder
module sfc_frame_assertions
  import sfc_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic       cs_n_in,
  input wire logic       prot_hit_in,
  input wire logic [3:0] io_oe_out,
  input wire logic       cmd_valid_out,
  input wire sfc_cmd_t   cmd_out,
  input wire logic       rd_req_out,
  input wire logic       write_enable_latch_out,
  input wire logic       deep_pd_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  // commands that alter the array
  wire is_mod = cmd_out.opcode inside {OP_PP, OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2};
  sequence sel_end;
    $rose(cs_n_in);
  endsequence
  cmd_after_cs_a: assert property (cmd_valid_out |-> cs_n_in && $past(cs_n_in, 3))
    else $error("command issued while selected");
  prot_block_a: assert property (cmd_valid_out && is_mod |-> !$past(prot_hit_in))
    else $error("protected target executed");
  latch_needed_a: assert property (cmd_valid_out && is_mod |-> $past(write_enable_latch_out))
    else $error("modify without write enable");
  latch_set_a: assert property ($rose(write_enable_latch_out) |-> $past(cs_n_in, 2))
    else $error("latch set inside frame");
  oe_release_a: assert property (sel_end |-> ##[1:6] io_oe_out == 4'h0)
    else $error("output still driven after deselect");
  oe_lanes_a: assert property (io_oe_out inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("bad lane enable");
  rdreq_frame_a: assert property (rd_req_out |-> !$past(cs_n_in, 2))
    else $error("read fetch while deselected");
  dpd_quiet_a: assert property (deep_pd_out && $past(deep_pd_out) |->
    $stable(write_enable_latch_out) && !cmd_valid_out)
    else $error("command run in power-down");
endmodule
bind sfc_frame sfc_frame_assertions chk (
  .clk_sys_in, .nrst_in, .cs_n_in, .prot_hit_in, .io_oe_out,
  .cmd_valid_out, .cmd_out, .rd_req_out, .write_enable_latch_out, .deep_pd_out
);

// file: testbench/sfc_host.sv
`timescale 1ns/100ps
// host controller: mode 0, serial clock parked low between frames
module sfc_host (
  input  wire logic       clk_in,
  input  wire logic [3:0] dev_io_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic      [3:0] io_out
);
  logic [63:0] rx_r;  // lanes seen at each rising serial edge
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out   = 4'h0;
    rx_r     = '0;
  end
  // n clocks (n <= 64), msb first, 17 system clocks per bit; the opcode goes on
  // lane 0, later bits on w lanes with the high lane carrying the higher bit
  task automatic frame(input logic [63:0] b, input int n, input int w);
    logic [63:0] sh;
    sh = b;
    @(posedge clk_in) cs_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      if (i < 8 || w == 1) io_out <= {3'h0, sh[63]};
      else if (w == 2) io_out <= {2'h0, sh[63:62]};
      else io_out <= sh[63:60];
      sh = sh << ((i < 8 || w == 1) ? 1 : w);
      repeat (8) @(posedge clk_in);
      sclk_out <= 1'b1;
      rx_r     <= {rx_r[59:0], dev_io_in};
      repeat (8) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    io_out   <= ~io_out;  // a released line must not keep its last bit
    repeat (12) @(posedge clk_in);
  endtask
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import sfc_pkg::*;
  logic       clk_sys_in = 1'b0;
  logic       nrst_in    = 1'b0;
  logic       cs_n, sclk, cv, wv, rq, we_latch, vsr, dpd;
  logic [3:0] io_h, io_d, oe, last_oe;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] wr_b, last_wr, dat;
  logic       prot    = 1'b0;
  sfc_cmd_t   cmd, last_cmd;
  logic [23:0] addr;
  int err_total   = 0;
  int check_count = 0;
  int seed        = 74;
  int n_cmd       = 0;
  int n_rd        = 0;
  int k, n;
  logic [7:0] mops [6] = '{OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2, OP_WRSR};
  int         mlen [6] = '{32, 32, 32, 8, 8, 16};
  logic [7:0] rops [6] = '{OP_RDSR1, OP_RDSR2, OP_READ, OP_FREAD, OP_DREAD, OP_QREAD};
  int         rhdr [6] = '{8, 8, 32, 40, 40, 40};
  int         rw   [6] = '{1, 1, 1, 1, 2, 4};
  logic [7:0] wops [3] = '{OP_OCTW, OP_QIO, OP_DIO};
  int         whdr [3] = '{16, 32, 24};
  int         ww   [3] = '{4, 4, 2};
  always #2.5 clk_sys_in = ~clk_sys_in;
  sfc_host host (.clk_in(clk_sys_in), .dev_io_in(io_d), .cs_n_out(cs_n), .sclk_out(sclk),
                 .io_out(io_h));
  sfc_frame dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .sclk_in(sclk),
                 .io_in(io_h), .io_out(io_d), .io_oe_out(oe), .rd_data_in(rd_data),
                 .prot_hit_in(prot), .cmd_valid_out(cv), .cmd_out(cmd), .wr_byte_valid_out(wv),
                 .wr_byte_out(wr_b), .rd_req_out(rq), .write_enable_latch_out(we_latch),
                 .vsr_wen_out(vsr), .deep_pd_out(dpd));
  // tally pulses and keep what they carried
  always @(posedge clk_sys_in) begin
    if (cv === 1'b1) begin
      n_cmd++;
      last_cmd = cmd;
    end
    if (wv === 1'b1) last_wr = wr_b;
    if (rq === 1'b1) n_rd++;
    if (oe !== 4'h0) last_oe = oe;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] op, input logic [31:0] tail, input int clocks);
    host.frame({op, tail, 24'h0}, clocks, 1);
  endtask
  // byte recovered from the last lane samples, high lanes carry high bits
  function automatic logic [7:0] got_byte(input logic [63:0] rx, input int w);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 8 / w - 1; i >= 0; i--) begin
      v = (w == 1) ? {v[6:0], rx[4*i+1]} : (w == 2) ? {v[5:0], rx[4*i+1 -: 2]}
                                                    : {v[3:0], rx[4*i+3 -: 4]};
    end
    return v;
  endfunction
  function automatic logic [3:0] lane_oe(input int w);
    return (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hf;
  endfunction
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    send(OP_WRITE_ENABLE_CMD, 0, 8);
    chk("latch set", 1, we_latch);
    send(OP_WRDIS, 0, 8);
    chk("latch clear", 0, we_latch);
    send(OP_WRITE_ENABLE_CMD, 0, 7);
    chk("latch cut", 0, we_latch);
    // every modifying opcode except page program, each behind a write enable
    for (k = 0; k < 6; k++) begin
      addr = 24'($random(seed));
      send(OP_WRITE_ENABLE_CMD, 0, 8);
      n = n_cmd;
      send(mops[k], {addr, 8'h5a}, mlen[k]);
      chk("mod count", n + 1, n_cmd);
      chk("mod op", mops[k], last_cmd.opcode);
      if (mlen[k] == 32) chk("mod addr", addr, last_cmd.addr);
    end
    // cut erase, protected erase, cut program: none may execute
    send(OP_WRITE_ENABLE_CMD, 0, 8);
    n = n_cmd;
    send(OP_SE, {addr, 8'h00}, 31);
    chk("cut erase", n, n_cmd);
    prot <= 1'b1;
    send(OP_BE64, {addr, 8'h00}, 32);
    prot <= 1'b0;
    chk("prot erase", n, n_cmd);
    send(OP_PP, {addr, 8'hc3}, 36);
    chk("cut pp", n, n_cmd);
    chk("cut pp latch", 1, we_latch);
    dat = 8'($random(seed));
    send(OP_PP, {addr, dat}, 40);
    chk("pp byte", dat, last_wr);
    // reads on one, two and four lanes, two data bytes each
    for (k = 0; k < 6; k++) begin
      rd_data <= 8'($random(seed));
      last_oe = 4'h0;
      send(rops[k], $random(seed), rhdr[k] + 16 / rw[k]);
      chk("rd byte", rd_data, got_byte(host.rx_r, rw[k]));
      chk("rd lanes", lane_oe(rw[k]), last_oe);
    end
    // wide-lane reads: address and mode on two or four lines, two data bytes each
    for (k = 0; k < 3; k++) begin
      addr = 24'($random(seed));
      dat = 8'($random(seed));
      rd_data <= 8'($random(seed));
      last_oe = 4'h0;
      host.frame({wops[k], addr, dat, 24'h0}, whdr[k] + 16 / ww[k], ww[k]);
      chk("wide byte", rd_data, got_byte(host.rx_r, ww[k]));
      chk("wide lanes", lane_oe(ww[k]), last_oe);
      chk("wide addr", addr, cmd.addr);
      chk("wide mode", dat, cmd.mode);
    end
    n = n_cmd;
    k = n_rd;
    send(8'hff, 32'hffffffff, 24);
    chk("unknown cmd", n, n_cmd);
    chk("unknown rd", k, n_rd);
    send(OP_VSR_EN, 0, 8);
    chk("vsr en", 1, vsr);
    send(OP_WRDIS, 0, 8);
    chk("vsr off", 0, vsr);
    send(OP_DPD, 0, 12);
    chk("dpd cut", 0, dpd);
    send(OP_DPD, 0, 8);
    chk("dpd on", 1, dpd);
    send(OP_WRITE_ENABLE_CMD, 0, 8);
    chk("dpd ignore", 0, we_latch);
    send(OP_RDP, 0, 8);
    chk("dpd off", 0, dpd);
    print_verdict();
  end
endmodule
